// ==== pscc_top.sv ====
// Supply control configuration block with its APB register slave.
`timescale 1ns/1ps
`include "pscc_regs.svh"
module pscc_top
	import pscc_pkg::*;
#(
	parameter int unsigned NUM_LEDS = 2,
	parameter int unsigned T0_CYC   = `PSCC_MS_TO_CYC(`PSCC_CROW0_MS),
	parameter int unsigned T1_CYC   = `PSCC_MS_TO_CYC(`PSCC_CROW1_MS),
	parameter int unsigned T2_CYC   = `PSCC_MS_TO_CYC(`PSCC_CROW2_MS),
	parameter int unsigned T3_CYC   = `PSCC_MS_TO_CYC(`PSCC_CROW3_MS)
) (
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	input  wire logic                      batRst,
	input  wire logic                      sbRst,
	input  wire logic                      standbyFail,
	input  wire logic                      supplyPolarityStrap,
	input  wire logic                      sleepStateInput,
	input  wire logic                      powerGood,
	input  wire logic [NUM_LEDS-1:0]       ledLit,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [`PSCC_ADDR_W-1:0]   paddr,
	input  wire logic [`PSCC_DATA_W-1:0]   pwdata,
	input  wire logic [3:0]                pstrb,
	output logic [`PSCC_DATA_W-1:0]        prdata_q,
	output logic                           pready_q,
	output logic                           pslverr_q,
	output logic                           supplyOnOutput_q,
	output logic [NUM_LEDS-1:0]            ledPin_q
);

	// ---------------------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------------------
	logic       ledPol;
	logic       lastOn;
	logic       supplyPol;
	logic [1:0] crowSel;
	logic       resumeBit;
	logic       modeBit;
	logic       crowTrip;
	logic       sleepPrev_q;
	logic       sbRstPrev_q;
	logic       supplyOn;
	logic       cfgWrite;
	logic       shutReq;
	logic       accessDone;
	logic [7:0] cfgRead;
	logic [7:0] statRead;
	pscc_pwr_t  pwrState_q;

	// ---------------------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------------------
	function automatic logic hitIdx(input logic [`PSCC_ADDR_W-1:0] a, input logic [7:0] idx);
		hitIdx = (a == {idx, 2'b00});
	endfunction

	assign accessDone = psel && penable && pready_q;
	// A write lands only at the edge where the master sees pready.
	assign cfgWrite   = accessDone && pwrite && pstrb[0] && hitIdx(paddr, `PSCC_CFG_IDX);
	// The off command is a strobe, never stored, and only counts in legacy mode.
	assign shutReq    = cfgWrite && pwdata[`PSCC_SHUT_BIT] && (modeBit == PSCC_LEGACY);

	// ---------------------------------------------------------------------------
	// Battery-backed fields and crowbar timer
	// ---------------------------------------------------------------------------
	pscc_bbram u_bbram (
		.clk           (clk),
		.batRst        (batRst),
		.sbRst         (sbRst),
		.wrEn          (cfgWrite),
		.wrData        (pwdata[7:0]),
		.sampleEn      (standbyFail),
		.sampleVal     (supplyOn),
		.polarityStrap (supplyPolarityStrap),
		.ledPol_q      (ledPol),
		.lastOn_q      (lastOn),
		.supplyPol_q   (supplyPol),
		.crowSel_q     (crowSel),
		.resume_q      (resumeBit),
		.mode_q        (modeBit)
	);

	// The timer runs while the supply is commanded on but the rails are not good.
	pscc_crowbar #(
		.T0_CYC (T0_CYC),
		.T1_CYC (T1_CYC),
		.T2_CYC (T2_CYC),
		.T3_CYC (T3_CYC)
	) u_crowbar (
		.clk     (clk),
		.sys_rst (sys_rst),
		.arm     (supplyOn && !powerGood),
		.sel     (crowSel),
		.trip_q  (crowTrip)
	);

	// ---------------------------------------------------------------------------
	// Supply state machine
	// ---------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sleepPrev_q <= 1'b0;
			sbRstPrev_q <= 1'b0;
		end else begin
			sleepPrev_q <= sleepStateInput;
			sbRstPrev_q <= sbRst;
		end
	end

	// Resume relies on the chipset starting in the off state, so the first
	// change of the sleep input hands control back to it.
	// A legacy off write in the release cycle still wins over the resume choice.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pwrState_q <= PSCC_FOLLOW;
		end else if (sbRstPrev_q && !sbRst && !shutReq) begin
			pwrState_q <= resumeBit ? PSCC_RESUME : PSCC_FOLLOW;
		end else begin
			unique case (pwrState_q)
				PSCC_FOLLOW: begin
					if (shutReq || crowTrip) begin
						pwrState_q <= PSCC_SHUT;
					end
				end
				PSCC_RESUME: begin
					if (shutReq || crowTrip) begin
						pwrState_q <= PSCC_SHUT;
					end else if (sleepStateInput != sleepPrev_q) begin
						pwrState_q <= PSCC_FOLLOW;
					end
				end
				PSCC_SHUT: begin
					if (sleepPrev_q && !sleepStateInput) begin
						pwrState_q <= PSCC_FOLLOW;
					end
				end
				default: begin
					pwrState_q <= PSCC_FOLLOW;
				end
			endcase
		end
	end

	always_comb begin
		unique case (pwrState_q)
			PSCC_RESUME: supplyOn = lastOn;
			PSCC_SHUT:   supplyOn = 1'b0;
			default:     supplyOn = sleepStateInput;
		endcase
	end

	// ---------------------------------------------------------------------------
	// Output pins
	// ---------------------------------------------------------------------------
	// Polarity 1 makes the pin active low; the supply stays off under standby reset.
	always_ff @(posedge clk) begin
		if (sys_rst || sbRst) begin
			supplyOnOutput_q <= supplyPol;
		end else begin
			supplyOnOutput_q <= supplyOn ^ supplyPol;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ledPin_q <= '0;
		end else begin
			ledPin_q <= ledLit ^ {NUM_LEDS{ledPol}};
		end
	end

	// ---------------------------------------------------------------------------
	// APB read data and handshake
	// ---------------------------------------------------------------------------
	always_comb begin
		cfgRead = 8'h00;
		cfgRead[`PSCC_LEDPOL_BIT] = ledPol;
		cfgRead[`PSCC_LASTON_BIT] = lastOn;
		cfgRead[`PSCC_SPOL_BIT] = supplyPol;
		cfgRead[`PSCC_CROW_HI:`PSCC_CROW_LO] = crowSel;
		cfgRead[`PSCC_RESUME_BIT] = resumeBit;
		cfgRead[`PSCC_SHUT_BIT] = 1'b0;
		cfgRead[`PSCC_MODE_BIT] = modeBit;
		statRead = 8'h00;
		statRead[`PSCC_ST_ON_BIT] = supplyOn;
		statRead[`PSCC_ST_TRIP_BIT] = (pwrState_q == PSCC_SHUT);
		statRead[`PSCC_ST_RES_BIT] = (pwrState_q == PSCC_RESUME);
	end

	// One wait state: pready rises in the second access cycle and lasts one cycle.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else if (psel && penable && !pready_q) begin
			pready_q  <= 1'b1;
			pslverr_q <= !(hitIdx(paddr, `PSCC_CFG_IDX) || hitIdx(paddr, `PSCC_STAT_IDX));
			if (pwrite) begin
				prdata_q <= '0;
			end else if (hitIdx(paddr, `PSCC_CFG_IDX)) begin
				prdata_q <= {24'h000000, cfgRead};
			end else if (hitIdx(paddr, `PSCC_STAT_IDX)) begin
				prdata_q <= {24'h000000, statRead};
			end else begin
				prdata_q <= '0;
			end
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_led_polarity: assert property (
		!batRst && !sbRst && $past(!batRst && !sbRst) |->
		ledPin_q == ($past(ledLit) ^ {NUM_LEDS{$past(ledPol)}}))
		else $error("LED pin does not follow lit state and polarity.");

	a_sb_defaults: assert property (
		sbRst |=> !ledPol && modeBit == PSCC_LEGACY)
		else $error("Standby reset did not restore LED polarity and legacy mode.");

	a_bat_defaults: assert property (
		batRst |=> crowSel == `PSCC_CROW_RST && !resumeBit)
		else $error("Battery reset did not restore crowbar and resume defaults.");

	a_strap_latch: assert property (
		!batRst && sbRst |=> supplyPol == $past(supplyPolarityStrap))
		else $error("Polarity strap was not latched during standby reset.");

	a_last_sample: assert property (
		!batRst && standbyFail |=> lastOn == $past(supplyOn))
		else $error("Supply state was not sampled at standby failure.");

	a_shut_legacy: assert property (
		shutReq && !sbRst |=> ##1 (supplyOnOutput_q == supplyPol) [*2])
		else $error("Legacy off write did not turn the supply off.");

	a_shut_acpi: assert property (
		cfgWrite && modeBit == PSCC_ACPI && pwrState_q == PSCC_FOLLOW && !crowTrip
		&& !sbRst && !(sbRstPrev_q && !sbRst) |=> pwrState_q != PSCC_SHUT)
		else $error("Off write took effect in ACPI mode.");

	a_read_bit1: assert property (
		pready_q && !pwrite && hitIdx(paddr, `PSCC_CFG_IDX) |-> !prdata_q[`PSCC_SHUT_BIT])
		else $error("Power supply off bit read back as one.");

	a_ro_ignore: assert property (
		cfgWrite && !batRst && !sbRst && !standbyFail |=>
		$stable(lastOn) && $stable(supplyPol))
		else $error("Write changed a read-only field.");

	a_resume_restore: assert property (
		sbRstPrev_q && !sbRst && resumeBit |=> ##1 supplyOnOutput_q == ($past(lastOn) ^ supplyPol)
		|| pwrState_q != PSCC_RESUME)
		else $error("Supply did not resume its last state.");

	// ---------------------------------------------------------------------------
	// Supply pin, crowbar shut, bus handshake and read data checks
	// ---------------------------------------------------------------------------
	a_follow_pin: assert property (
		!sbRst && pwrState_q == PSCC_FOLLOW |=>
		supplyOnOutput_q == ($past(sleepStateInput) ^ $past(supplyPol)))
		else $error("Supply pin does not follow the sleep input.");

	a_shut_pin: assert property (
		!sbRst && pwrState_q == PSCC_SHUT |=> supplyOnOutput_q == $past(supplyPol))
		else $error("Supply pin is not off in the shut state.");

	a_sb_pin_off: assert property (
		sbRst |=> supplyOnOutput_q == $past(supplyPol))
		else $error("Supply pin is not off during standby reset.");

	a_crow_shut: assert property (
		crowTrip && pwrState_q != PSCC_SHUT && !(sbRstPrev_q && !sbRst) |=>
		pwrState_q == PSCC_SHUT)
		else $error("Crowbar trip did not shut the supply off.");

	a_apb_wait: assert property (
		psel && penable && !pready_q |=> pready_q)
		else $error("Access was not answered after one wait state.");

	a_apb_pulse: assert property (
		pready_q |=> !pready_q)
		else $error("Ready stayed high for more than one cycle.");

	a_unmapped_zero: assert property (
		pready_q && pslverr_q |-> prdata_q == '0)
		else $error("Unmapped access returned nonzero data.");

	a_upper_zero: assert property (
		pready_q && !pwrite && !pslverr_q |-> prdata_q[31:8] == 24'h000000)
		else $error("Upper read data bits are not zero.");

endmodule

// ==== pscc_regs.svh ====
// Register map, field positions, reset values and timing constants of the supply control block.
// What this block does
// - Keep crowbar range and resume settings in battery-backed storage surviving loss of standby power.
// - Configuration register sits at configuration index 2Dh, access type per bit.
// - Bit 7 LED polarity: 0 lit active high, 1 lit active low; standby default 0.
// - Bit 6 reports supply-on state sampled at last standby failure, polarity independent.
// - Bit 5 shows supply-on polarity latched from strap at standby power-up; drives output.
// - Bits 4-3 pick crowbar timeout range; battery power-up default 11.
// - Resume bit 2 restores last supply state after power returns, else follow sleep.
// - Writing 1 to bit 1 in legacy mode shuts supply off; reads return 0.
// - Bit 0 selects button mode: 0 legacy, 1 ACPI; standby default legacy.
`ifndef PSCC_REGS_SVH
`define PSCC_REGS_SVH

// ---------------------------------------------------------------------------
// Register indices and bus geometry
// ---------------------------------------------------------------------------
`define PSCC_ADDR_W      10
`define PSCC_CFG_IDX     8'h2D
`define PSCC_STAT_IDX    8'h2E
`define PSCC_DATA_W      32

// ---------------------------------------------------------------------------
// Field positions of the configuration register
// ---------------------------------------------------------------------------
`define PSCC_LEDPOL_BIT  7
`define PSCC_LASTON_BIT  6
`define PSCC_SPOL_BIT    5
`define PSCC_CROW_HI     4
`define PSCC_CROW_LO     3
`define PSCC_RESUME_BIT  2
`define PSCC_SHUT_BIT    1
`define PSCC_MODE_BIT    0

// ---------------------------------------------------------------------------
// Field positions of the status register
// ---------------------------------------------------------------------------
`define PSCC_ST_ON_BIT   0
`define PSCC_ST_TRIP_BIT 1
`define PSCC_ST_RES_BIT  2

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define PSCC_LEDPOL_RST  1'h0
`define PSCC_MODE_RST    1'h0
`define PSCC_CROW_RST    2'h3
`define PSCC_RESUME_RST  1'h0
`define PSCC_LASTON_RST  1'h0
`define PSCC_SPOL_RST    1'h0

// ---------------------------------------------------------------------------
// Crowbar timing: least time of each range in milliseconds
// ---------------------------------------------------------------------------
`define PSCC_CLK_KHZ     125000
`define PSCC_CROW0_MS    500
`define PSCC_CROW1_MS    1000
`define PSCC_CROW2_MS    1250
`define PSCC_CROW3_MS    2000
`define PSCC_MS_TO_CYC(ms) ((ms) * `PSCC_CLK_KHZ)

`endif

// ==== pscc_pkg.sv ====
// Types shared by the supply control block.
package pscc_pkg;

	typedef enum logic {
		PSCC_LEGACY,
		PSCC_ACPI
	} pscc_mode_t;

	typedef enum logic [1:0] {
		PSCC_FOLLOW,
		PSCC_RESUME,
		PSCC_SHUT
	} pscc_pwr_t;

endpackage

// ==== pscc_bbram.sv ====
// Battery-backed storage of the configuration register fields.
`timescale 1ns/1ps
`include "pscc_regs.svh"
module pscc_bbram
	import pscc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       batRst,
	input  wire logic       sbRst,
	input  wire logic       wrEn,
	input  wire logic [7:0] wrData,
	input  wire logic       sampleEn,
	input  wire logic       sampleVal,
	input  wire logic       polarityStrap,
	output logic            ledPol_q,
	output logic            lastOn_q,
	output logic            supplyPol_q,
	output logic [1:0]      crowSel_q,
	output logic            resume_q,
	output logic            mode_q
);

	// ---------------------------------------------------------------------------
	// Fields that fall back to defaults on standby power-up
	// ---------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (batRst || sbRst) begin
			ledPol_q <= `PSCC_LEDPOL_RST;
			mode_q   <= `PSCC_MODE_RST;
		end else if (wrEn) begin
			ledPol_q <= wrData[`PSCC_LEDPOL_BIT];
			mode_q   <= wrData[`PSCC_MODE_BIT];
		end
	end

	// ---------------------------------------------------------------------------
	// Fields that only a battery power-up clears
	// ---------------------------------------------------------------------------
	// Only the battery reset touches these, so a standby loss keeps them.
	always_ff @(posedge clk) begin
		if (batRst) begin
			crowSel_q <= `PSCC_CROW_RST;
			resume_q  <= `PSCC_RESUME_RST;
		end else if (wrEn) begin
			crowSel_q <= wrData[`PSCC_CROW_HI:`PSCC_CROW_LO];
			resume_q  <= wrData[`PSCC_RESUME_BIT];
		end
	end

	// ---------------------------------------------------------------------------
	// Supply state captured at a standby failure
	// ---------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (batRst) begin
			lastOn_q <= `PSCC_LASTON_RST;
		end else if (sampleEn) begin
			lastOn_q <= sampleVal;
		end
	end

	// ---------------------------------------------------------------------------
	// Polarity strap, caught while the standby reset is held
	// ---------------------------------------------------------------------------
	// Host writes never reach this or the sampled state.
	always_ff @(posedge clk) begin
		if (batRst) begin
			supplyPol_q <= `PSCC_SPOL_RST;
		end else if (sbRst) begin
			supplyPol_q <= polarityStrap;
		end
	end

endmodule

// ==== pscc_crowbar.sv ====
// Crowbar timer: trips when the supply stays on without power good for the chosen time.
`timescale 1ns/1ps
`include "pscc_regs.svh"
module pscc_crowbar
	import pscc_pkg::*;
#(
	parameter int unsigned T0_CYC = `PSCC_MS_TO_CYC(`PSCC_CROW0_MS),
	parameter int unsigned T1_CYC = `PSCC_MS_TO_CYC(`PSCC_CROW1_MS),
	parameter int unsigned T2_CYC = `PSCC_MS_TO_CYC(`PSCC_CROW2_MS),
	parameter int unsigned T3_CYC = `PSCC_MS_TO_CYC(`PSCC_CROW3_MS)
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       arm,
	input  wire logic [1:0] sel,
	output logic            trip_q
);

	logic [31:0] count_q;

	// Least time of each range is used, so the trip never comes early.
	function automatic logic [31:0] limitOf(input logic [1:0] s);
		unique case (s)
			2'h0: limitOf = T0_CYC;
			2'h1: limitOf = T1_CYC;
			2'h2: limitOf = T2_CYC;
			2'h3: limitOf = T3_CYC;
		endcase
	endfunction

	always_ff @(posedge clk) begin
		if (sys_rst || !arm) begin
			count_q <= 32'h0;
		end else if (count_q < limitOf(sel)) begin
			count_q <= count_q + 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trip_q <= 1'b0;
		end else begin
			trip_q <= arm && (count_q == limitOf(sel) - 32'h1);
		end
	end

endmodule

// ==== pscc_supply_model.sv ====
// Behavioural model of the system power supply and the chipset sleep signal.
`timescale 1ns/1ps
module pscc_supply_model #(
	parameter int GOOD_DLY = 3
) (
	input  wire logic clk,
	input  wire logic supplyPin,
	input  wire logic supplyPol,
	input  wire logic wantRun,
	input  wire logic standbyFail,
	input  wire logic dropGood,
	output logic      sleepState,
	output logic      powerGood
);
	int   goodCnt = 0;
	logic lostRun = 1'b0;

	// After a full failure the chipset comes back off and waits for a new run request.
	always_ff @(posedge clk) begin
		if (standbyFail)
			lostRun <= 1'b1;
		else if (!wantRun)
			lostRun <= 1'b0;
		sleepState <= wantRun && !lostRun && !standbyFail;
	end

	// Power good rises a few cycles after the supply turns on; dropGood forces a fault.
	always_ff @(posedge clk) begin
		if ((supplyPin ^ supplyPol) !== 1'b1)
			goodCnt <= 0;
		else if (goodCnt < GOOD_DLY)
			goodCnt <= goodCnt + 1;
		powerGood <= (goodCnt == GOOD_DLY) && !dropGood;
	end
endmodule

// ==== tb_pscc_top.sv ====
// Self-checking testbench of the supply control configuration block.
`timescale 1ns/1ps
`include "pscc_regs.svh"
module tb_pscc_top;
	import pscc_pkg::*;

	localparam logic [9:0] CFG_A  = {`PSCC_CFG_IDX, 2'b00};
	localparam logic [9:0] STAT_A = {`PSCC_STAT_IDX, 2'b00};

	logic        clk = 1'b0;
	logic        sysRst = 1'b1, batRst = 1'b1, sbRst = 1'b1;
	logic        standbyFail = 1'b0, strap = 1'b0, wantRun = 1'b0, dropGood = 1'b0;
	logic        sleepState, powerGood;
	logic [1:0]  ledLit = 2'h0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [9:0]  paddr = 10'h000;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] pwdata = 32'h0, prdata, rd, r;
	logic        pready, pslverr, er, supplyPin;
	logic [1:0]  ledPin;
	logic [7:0]  expCfg = 8'h18;
	int          bad_count = 0, n_checks = 0, cycles = 0, seed = 27759;

	always #4 clk = ~clk;

	pscc_top #(.NUM_LEDS(2), .T0_CYC(20), .T1_CYC(40), .T2_CYC(50), .T3_CYC(80)) pscc_top_inst (
		.clk(clk), .sys_rst(sysRst), .batRst(batRst), .sbRst(sbRst),
		.standbyFail(standbyFail), .supplyPolarityStrap(strap),
		.sleepStateInput(sleepState), .powerGood(powerGood), .ledLit(ledLit),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata_q(prdata), .pready_q(pready),
		.pslverr_q(pslverr), .supplyOnOutput_q(supplyPin), .ledPin_q(ledPin));

	pscc_supply_model pscc_supply_model_inst (
		.clk(clk), .supplyPin(supplyPin), .supplyPol(expCfg[5]), .wantRun(wantRun),
		.standbyFail(standbyFail), .dropGood(dropGood), .sleepState(sleepState),
		.powerGood(powerGood));

	// ---------------------------------------------------------------------------
	// Reporting
	// ---------------------------------------------------------------------------
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] t=%0t data got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic cmp_pin(input logic [1:0] g, input logic [1:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] t=%0t pin got=%h exp=%h", $time, g, e);
		end
	endtask

	// The deadline covers the whole sequence with a wide margin.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			conclude();
		end
	end

	// ---------------------------------------------------------------------------
	// APB master
	// ---------------------------------------------------------------------------
	// The answer is taken at the edge where pready is seen high; only the
	// bench timeout ends a wait that never gets one.
	task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] d);
		apb(1'b1, CFG_A, d);
		expCfg = (d & 8'h9D) | (expCfg & 8'h60);
	endtask

	task automatic rdc(input logic [9:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		cmp_data(rd, e);
	endtask

	// The low pulse gives the falling sleep edge that leaves the shut state.
	task automatic run_cycle;
		wantRun <= 1'b1;
		repeat (2) @(posedge clk);
		wantRun <= 1'b0;
		repeat (4) @(posedge clk);
		wantRun <= 1'b1;
		repeat (6) @(posedge clk);
	endtask

	// ---------------------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		sysRst <= 1'b0;
		batRst <= 1'b0;
		sbRst <= 1'b0;
		rdc(CFG_A, {24'h0, expCfg});
		apb(1'b0, 10'h3FC, 8'h00);
		cmp_data(rd, 32'h0);
		cmp_data({31'h0, er}, 32'h1);
		pstrb <= 4'hE;
		apb(1'b1, CFG_A, 8'h81);
		pstrb <= 4'hF;
		rdc(CFG_A, {24'h0, expCfg});
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			wr(r[7:0]);
			rdc(CFG_A, {24'h0, expCfg});
		end
		wr(8'h80);
		r = $random(seed);
		ledLit <= r[1:0];
		repeat (3) @(posedge clk);
		cmp_pin(ledPin, ledLit ^ 2'h3);
		wr(8'h00);
		run_cycle();
		cmp_pin({1'b0, supplyPin}, 2'h1);
		standbyFail <= 1'b1;
		@(posedge clk);
		standbyFail <= 1'b0;
		expCfg = expCfg | 8'h40;
		repeat (4) @(posedge clk);
		cmp_pin({1'b0, supplyPin}, 2'h0);
		rdc(CFG_A, {24'h0, expCfg});
		run_cycle();
		wr(8'h02);
		repeat (3) @(posedge clk);
		cmp_pin({1'b0, supplyPin}, 2'h0);
		rdc(STAT_A, 32'h2);
		rdc(CFG_A, {24'h0, expCfg});
		run_cycle();
		wr(8'h01);
		wr(8'h03);
		repeat (3) @(posedge clk);
		cmp_pin({1'b0, supplyPin}, 2'h1);
		wr(8'h01);
		dropGood <= 1'b1;
		repeat (15) @(posedge clk);
		cmp_pin({1'b0, supplyPin}, 2'h1);
		repeat (15) @(posedge clk);
		cmp_pin({1'b0, supplyPin}, 2'h0);
		dropGood <= 1'b0;
		wr(8'h84);
		strap <= 1'b1;
		sbRst <= 1'b1;
		repeat (4) @(posedge clk);
		sbRst <= 1'b0;
		expCfg = (expCfg & 8'h5C) | 8'h20;
		repeat (4) @(posedge clk);
		cmp_pin({1'b0, supplyPin}, 2'h0);
		rdc(CFG_A, {24'h0, expCfg});
		rdc(STAT_A, 32'h5);
		batRst <= 1'b1;
		repeat (4) @(posedge clk);
		batRst <= 1'b0;
		expCfg = 8'h18;
		rdc(CFG_A, {24'h0, expCfg});
		conclude();
	end
endmodule
